/* core/code_expander.sv */
// Expands one packed shift/mantissa code into its linear value.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module code_expander (
   input  wire logic [6:0]  code_in,
   output logic      [10:0] value_out
);
   logic [3:0] mantissa;
   logic [2:0] shift;

   assign mantissa  = code_in[motor_param_pkg::MANT_LSB +: motor_param_pkg::MANT_W];
   assign shift     = code_in[motor_param_pkg::SHIFT_LSB +: motor_param_pkg::SHIFT_W];
   assign value_out = {7'h00, mantissa} << shift;

endmodule : code_expander

/* core/motor_param_code_decoder.sv */
// Motor parameter code decoder: registers linear back-EMF and resistance values,
// the expected back-EMF level, and the initial motor condition at start-up.
// Assumes all inputs come from logic on clk_in; no synchronisers needed.
`timescale 1ns/1ps
module motor_param_code_decoder (
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic [7:0]  motor_cfg_first_in,
   input  wire logic [7:0]  motor_cfg_second_in,
   input  wire logic [15:0] elec_freq_in,
   input  wire logic        start_req_in,
   input  wire logic        motor_moving_in,
   input  wire logic        motor_forward_in,
   output logic      [10:0] bemf_value_out,
   output logic      [10:0] phase_res_value_out,
   output logic      [26:0] expected_bemf_out,
   output logic      [1:0]  start_cond_out,
   output logic             bemf_set_out,
   output logic             phase_res_set_out
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [10:0]                   bemf_val;
      logic [10:0]                   res_val;
      logic [26:0]                   volt;
      motor_param_pkg::start_cond_t  cond;
      logic                          bemf_set;
      logic                          res_set;
   } dec_state_t;

   dec_state_t  st;
   dec_state_t  next_st;

   logic [6:0]  bemf_const_code;
   logic [6:0]  phase_res_code;
   logic [2:0]  bemf_const_shift;
   logic [3:0]  bemf_const_mantissa;
   logic [10:0] bemf_lin;
   logic [10:0] res_lin;

   // -------------------------------------------------------------------
   // Field extraction
   // -------------------------------------------------------------------
   // Back-EMF code lives in the second word, resistance in the first
   assign bemf_const_code = motor_cfg_second_in[motor_param_pkg::CODE_LSB +:
                                                motor_param_pkg::CODE_W];
   assign phase_res_code  = motor_cfg_first_in[motor_param_pkg::CODE_LSB +:
                                               motor_param_pkg::CODE_W];
   // Split kept visible for the checks below
   assign bemf_const_shift    = bemf_const_code[motor_param_pkg::SHIFT_LSB +:
                                                motor_param_pkg::SHIFT_W];
   assign bemf_const_mantissa = bemf_const_code[motor_param_pkg::MANT_LSB +:
                                                motor_param_pkg::MANT_W];

   // -------------------------------------------------------------------
   // Expanders
   // -------------------------------------------------------------------
   // Same scheme for both codes, so one expander serves each
   code_expander u_bemf_exp (
      .code_in   (bemf_const_code),
      .value_out (bemf_lin)
   );

   code_expander u_res_exp (
      .code_in   (phase_res_code),
      .value_out (res_lin)
   );

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb begin
      next_st          = st;
      // Value weight is 1090 per V/Hz; resistance weight 9.67 mOhm
      next_st.bemf_val = bemf_lin;
      next_st.res_val  = res_lin;
      next_st.bemf_set = (bemf_lin != motor_param_pkg::VALUE_RST);
      next_st.res_set  = (res_lin != motor_param_pkg::VALUE_RST);
      // Ratio times frequency gives the phase-to-phase level, scaled by 1090.
      // Uses the registered ratio so the level settles two cycles after a code change.
      // Both factors widened first; a bare product would wrap at the 16-bit operand width
      next_st.volt     = 27'(st.bemf_val) * 27'(elec_freq_in);
      if (start_req_in) begin
         if (!motor_moving_in) begin
            next_st.cond = motor_param_pkg::COND_STATIONARY;
         end else if (motor_forward_in) begin
            next_st.cond = motor_param_pkg::COND_FORWARD;
         end else begin
            next_st.cond = motor_param_pkg::COND_REVERSE;
         end
      end
   end

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         st.bemf_val <= motor_param_pkg::VALUE_RST;
         st.res_val  <= motor_param_pkg::VALUE_RST;
         st.volt     <= motor_param_pkg::VOLT_RST;
         st.cond     <= motor_param_pkg::COND_NONE;
         st.bemf_set <= 1'b0;
         st.res_set  <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign bemf_value_out      = st.bemf_val;
   assign phase_res_value_out = st.res_val;
   assign expected_bemf_out   = st.volt;
   assign start_cond_out      = st.cond;
   assign bemf_set_out        = st.bemf_set;
   assign phase_res_set_out   = st.res_set;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_bemf_code_change;
      !$stable(bemf_const_code);
   endsequence

   sequence s_bemf_follows;
      bemf_value_out == ({7'h00, $past(bemf_const_mantissa)} << $past(bemf_const_shift));
   endsequence

   sequence s_moving_start;
      start_req_in && motor_moving_in;
   endsequence

   a_field_split: assert property (
      1'b1 |=> bemf_value_out ==
               ({7'h00, $past(bemf_const_code[3:0])} << $past(bemf_const_code[6:4])))
      else $error("back-EMF value does not follow code fields");

   a_bemf_expand: assert property (s_bemf_code_change |=> s_bemf_follows)
      else $error("back-EMF value not updated after code change");

   a_bemf_max: assert property (
      bemf_const_code == motor_param_pkg::CODE_ALL_ONES |=>
         bemf_value_out == motor_param_pkg::VALUE_MAX)
      else $error("all-ones back-EMF code not decoded to maximum");

   a_bemf_min: assert property (
      bemf_const_code == motor_param_pkg::CODE_LSB_ONLY |=>
         bemf_value_out == motor_param_pkg::VALUE_MIN)
      else $error("lowest back-EMF code not decoded to one");

   a_volt_ratio: assert property (
      $past(sys_rst_in) == 1'b0 |->
         expected_bemf_out == 27'($past(bemf_value_out)) * 27'($past(elec_freq_in)))
      else $error("expected back-EMF not ratio times frequency");

   a_cond_still: assert property (
      start_req_in && !motor_moving_in |=>
         start_cond_out == motor_param_pkg::COND_STATIONARY)
      else $error("stationary start not recognised");

   a_cond_moving: assert property (
      s_moving_start |=> start_cond_out ==
         ($past(motor_forward_in) ? motor_param_pkg::COND_FORWARD
                                  : motor_param_pkg::COND_REVERSE))
      else $error("turning direction at start misclassified");

   a_cond_hold: assert property (
      !start_req_in |=> $stable(start_cond_out))
      else $error("start condition changed without request");

   a_res_expand: assert property (
      !$stable(phase_res_code) |=> phase_res_value_out ==
         ({7'h00, $past(phase_res_code[3:0])} << $past(phase_res_code[6:4])))
      else $error("resistance value not updated after code change");

   // The first edge after reset reloads from zero, so it is left out here
   a_res_stable: assert property (
      (!$past(sys_rst_in) && $stable(phase_res_code)) ##1 $stable(phase_res_code)
         |-> $stable(phase_res_value_out))
      else $error("resistance value moved with steady code");

   a_bemf_stable: assert property (
      (!$past(sys_rst_in) && $stable(bemf_const_code)) ##1 $stable(bemf_const_code)
         |-> $stable(bemf_value_out))
      else $error("back-EMF value moved with steady code");

   a_reset_clear: assert property (
      disable iff (1'b0)
      sys_rst_in |=> bemf_value_out == 11'h000 && phase_res_value_out == 11'h000
                     && !bemf_set_out && !phase_res_set_out)
      else $error("decoded values not cleared by reset");

   a_set_flag: assert property (
      1'b1 |=> bemf_set_out == (bemf_value_out != 11'h000))
      else $error("back-EMF programmed flag disagrees with value");

   a_res_flag: assert property (
      1'b1 |=> phase_res_set_out == (phase_res_value_out != motor_param_pkg::VALUE_RST))
      else $error("resistance programmed flag disagrees with value");

   a_res_max: assert property (
      phase_res_code == motor_param_pkg::CODE_ALL_ONES |=>
         phase_res_value_out == motor_param_pkg::VALUE_MAX)
      else $error("all-ones resistance code not decoded to maximum");

   a_res_min: assert property (
      phase_res_code == motor_param_pkg::CODE_LSB_ONLY |=>
         phase_res_value_out == motor_param_pkg::VALUE_MIN)
      else $error("lowest resistance code not decoded to one");

endmodule : motor_param_code_decoder

/* core/motor_param_pkg.sv */
// Constants shared by the motor-parameter code decoder and its expander.
// Assumes codes arrive in the low seven bits of eight-bit configuration words.
package motor_param_pkg;

   // -------------------------------------------------------------------
   // Code field layout
   // -------------------------------------------------------------------
   localparam int CFG_W       = 8;
   localparam int CODE_W      = 7;
   localparam int CODE_LSB    = 0;
   localparam int MANT_W      = 4;
   localparam int MANT_LSB    = 0;
   localparam int SHIFT_W     = 3;
   localparam int SHIFT_LSB   = 4;
   localparam int VALUE_W     = 11;
   localparam int FREQ_W      = 16;
   localparam int VOLT_W      = VALUE_W + FREQ_W;

   // -------------------------------------------------------------------
   // Scaling and reset values
   // -------------------------------------------------------------------
   localparam int BEMF_WEIGHT_PER_VHZ       = 1090;
   localparam int RES_LSB_MICRO_OHM         = 9670;
   localparam logic [10:0] VALUE_MAX        = 11'h780;
   localparam logic [10:0] VALUE_MIN        = 11'h001;
   localparam logic [6:0]  CODE_ALL_ONES    = 7'h7F;
   localparam logic [6:0]  CODE_LSB_ONLY    = 7'h01;
   localparam logic [10:0] VALUE_RST        = 11'h000;
   localparam logic [26:0] VOLT_RST         = 27'h0000000;

   // -------------------------------------------------------------------
   // Initial motor condition seen at start-up
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      COND_NONE       = 2'h0,
      COND_STATIONARY = 2'h1,
      COND_FORWARD    = 2'h3,
      COND_REVERSE    = 2'h2
   } start_cond_t;

endpackage : motor_param_pkg

/* dv/motor_side.sv */
// Far-side model: software writing the config words, plus the motor state.
// Assumes the bench calls its tasks; every change lands on a falling edge.
`timescale 1ns/1ps
module motor_side (
   input  wire logic        clk_in,
   output logic      [7:0]  motor_cfg_first_out,
   output logic      [7:0]  motor_cfg_second_out,
   output logic      [15:0] elec_freq_out,
   output logic             start_req_out,
   output logic             motor_moving_out,
   output logic             motor_forward_out
);
   initial begin
      motor_cfg_first_out  = 8'h00;
      motor_cfg_second_out = 8'h00;
      elec_freq_out        = 16'h0000;
      start_req_out        = 1'b0;
      motor_moving_out     = 1'b0;
      motor_forward_out    = 1'b0;
   end

   task automatic program_codes(input logic [6:0] res_code, input logic [6:0] bemf_code,
                                input logic top_bit, input logic [15:0] freq);
      @(negedge clk_in);
      motor_cfg_first_out  = {top_bit, res_code};
      motor_cfg_second_out = {~top_bit, bemf_code};
      elec_freq_out        = freq;
   endtask : program_codes

   task automatic request_start(input logic moving, input logic forward);
      @(negedge clk_in);
      motor_moving_out  = moving;
      motor_forward_out = forward;
      start_req_out     = 1'b1;
      @(negedge clk_in);
      start_req_out     = 1'b0;
      // Flip the condition so a captured value that drifts shows up
      motor_moving_out  = ~moving;
      motor_forward_out = ~forward;
   endtask : request_start
endmodule : motor_side

/* dv/testbench.sv */
// Self-checking bench for the motor parameter code decoder.
// Assumes one 50 MHz clock; inputs change on falling edges only.
`timescale 1ns/1ps
module testbench;
   logic        clk_in     = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic [7:0]  cfg_first, cfg_second;
   logic [15:0] freq;
   logic        start_req, moving, forward;
   logic [10:0] bemf_value, res_value;
   logic [26:0] exp_bemf;
   logic [1:0]  start_cond;
   logic        bemf_set, res_set;
   int          num_errors = 0;
   int          num_checks = 0;
   int          cycles     = 0;

   initial forever #10 clk_in = ~clk_in;

   motor_side motor_u (.clk_in(clk_in), .motor_cfg_first_out(cfg_first),
      .motor_cfg_second_out(cfg_second), .elec_freq_out(freq), .start_req_out(start_req),
      .motor_moving_out(moving), .motor_forward_out(forward));

   motor_param_code_decoder dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .motor_cfg_first_in(cfg_first), .motor_cfg_second_in(cfg_second),
      .elec_freq_in(freq), .start_req_in(start_req), .motor_moving_in(moving),
      .motor_forward_in(forward), .bemf_value_out(bemf_value),
      .phase_res_value_out(res_value), .expected_bemf_out(exp_bemf),
      .start_cond_out(start_cond), .bemf_set_out(bemf_set), .phase_res_set_out(res_set));

   task automatic test_done;
      if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done

   task automatic chk(input logic [26:0] got, input logic [26:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask : chk

   function automatic logic [10:0] expand(input logic [6:0] code);
      expand = {7'h00, code[3:0]} << code[6:4];
   endfunction : expand

   task automatic check_zero;
      chk(27'(bemf_value), 27'h0, "bemf after reset");
      chk(27'(res_value), 27'h0, "res after reset");
      chk(exp_bemf, 27'h0, "level after reset");
      chk(27'({start_cond, bemf_set, res_set}), 27'h0, "flags after reset");
   endtask : check_zero

   task automatic test_decode;
      for (int i = 0; i < 128; i++) begin
         motor_u.program_codes(7'(i), 7'(127 - i), i[0], 16'h0003);
         @(negedge clk_in);
         chk(27'(bemf_value), 27'(expand(7'(127 - i))), "bemf decode");
         chk(27'(res_value), 27'(expand(7'(i))), "res decode");
         chk(27'(bemf_set), 27'(expand(7'(127 - i)) != 0), "bemf set");
         chk(27'(res_set), 27'(expand(7'(i)) != 0), "res set");
      end
   endtask : test_decode

   task automatic test_bounds;
      motor_u.program_codes(7'h01, 7'h7F, 1'b0, 16'h03E8);
      @(negedge clk_in);
      chk(27'(bemf_value), 27'h780, "bemf max");
      @(negedge clk_in);
      chk(exp_bemf, 27'(1920 * 1000), "level at max");
      motor_u.program_codes(7'h7F, 7'h01, 1'b1, 16'h0007);
      @(negedge clk_in);
      chk(27'(bemf_value), 27'h001, "bemf min");
      chk(exp_bemf, 27'(1920 * 7), "level after freq");
      @(negedge clk_in);
      chk(exp_bemf, 27'h7, "level at min");
   endtask : test_bounds

   task automatic test_start;
      logic [1:0] mv [3] = '{2'b00, 2'b11, 2'b10};
      logic [1:0] ex [3] = '{2'h1, 2'h3, 2'h2};
      for (int i = 0; i < 3; i++) begin
         motor_u.request_start(mv[i][1], mv[i][0]);
         chk(27'(start_cond), 27'(ex[i]), "start condition");
      end
      repeat (3) @(negedge clk_in);
      chk(27'(start_cond), 27'h2, "condition held");
   endtask : test_start

   task automatic test_mid_reset;
      @(negedge clk_in);
      sys_rst_in = 1'b1;
      @(negedge clk_in);
      check_zero();
      sys_rst_in = 1'b0;
      // Codes still hold resistance 0x7F, back-EMF 0x01, frequency 7
      @(negedge clk_in);
      chk(27'(res_value), 27'h780, "res reload");
      chk(27'(bemf_value), 27'h001, "bemf reload");
      chk(exp_bemf, 27'h0, "level first edge");
      chk(27'(start_cond), 27'h0, "cond after reset");
      @(negedge clk_in);
      chk(exp_bemf, 27'h7, "level second edge");
      chk(27'(res_value), 27'h780, "res steady");
   endtask : test_mid_reset

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         test_done();
      end
   end

   initial begin
      repeat (16) @(negedge clk_in);
      check_zero();
      sys_rst_in = 1'b0;
      test_decode();
      test_bounds();
      test_start();
      test_mid_reset();
      test_done();
   end
endmodule : testbench
